/* File: ars_core.sv */
`timescale 1ns/1ps
`include "ars_params.svh"
// ==========================================================================
// Architectural register state
// ==========================================================================
// Summary of operation
// - Longwords move via single-precision load/store path
// - Bit 62 and 58:45 carry upper integer
// - Bits 61:59 ignored by store and by operates on port b only
// - Longword operate writes zeros to 61:59
// - Quadwords move via double-precision load/store
// - Double load/store copies bits unchanged
// - Double store does not check register contents
// - Program counter advances at each decode without a redirect
// - Counter keeps bits 63:2; 1:0 read zero
// - Counter not addressable as integer register
// - Thirty-two 64-bit integer registers per processor
// - Integer zero register always reads zero
// - Writes to integer zero register discarded
// - Fetch exceptions still raised for zero destinations
// - Jumps linking to zero register still redirect
// - Thirty-two 64-bit floating registers per processor
// - Floating zero register reads true zero
// - Single-precision ops read/write all 64 bits
// - Reservation flag and reserved address held
// - Reserve load to zero register leaves reservation undefined
// - Prefetch state held, invisible to software
// - Single load widens exponent 8 to 11
// - Single load clears 28:0; store ignores them
module ars_core
   import ars_pkg::*;
#(
   parameter int XLEN  = `ARS_XLEN,
   parameter int NREGS = `ARS_NREGS
) (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // Program counter control
   input  wire logic        decode_in,
   input  wire logic        redirect_in,
   input  wire logic [63:0] target_in,
   output logic [63:0]      program_counter_out,
   // Integer file
   input  wire logic [4:0]  int_ra_in,
   input  wire logic [4:0]  int_rb_in,
   output logic [63:0]      int_ra_data_out,
   output logic [63:0]      int_rb_data_out,
   input  wire logic        int_wr_en_in,
   input  wire logic [4:0]  int_wr_idx_in,
   input  wire logic [63:0] int_wr_data_in,
   input  wire logic        link_wr_in,
   // Floating file
   input  wire logic [4:0]  fp_ra_in,
   input  wire logic [4:0]  fp_rb_in,
   output logic [63:0]      fp_ra_data_out,
   output logic [63:0]      fp_rb_data_out,
   input  wire logic        fp_wr_en_in,
   input  wire logic [4:0]  fp_wr_idx_in,
   input  wire logic [63:0] fp_wr_data_in,
   input  wire logic        lw_operate_in,
   // Floating memory moves
   input  wire logic [1:0]  load_kind_in,
   input  wire logic [63:0] load_mem_data_in,
   input  wire logic [1:0]  store_kind_in,
   output logic [63:0]      store_mem_data_out,
   // Fetch fault
   input  wire logic        fetch_fault_in,
   output logic             fetch_fault_out,
   // Reservation
   input  wire logic        load_reserve_op_in,
   input  wire logic        store_reserve_op_in,
   input  wire logic        reserve_clear_in,
   input  wire logic [63:0] reserve_addr_in,
   output logic             lock_flag_out,
   output logic [63:0]      lock_addr_out,
   // Prefetch state
   input  wire logic        prefetch_in,
   input  wire logic        prefetch_mod_in,
   input  wire logic [63:0] prefetch_addr_in
);
   // ======================================================================
   // State
   // ======================================================================
   typedef struct packed {
      logic [63:2] pc;
      logic        lock_flag;
      logic [63:0] lock_addr;
      logic [63:0] prefetch_a;
      logic [63:0] prefetch_b;
      logic        prefetch_sel;
      // Modify intent of each prefetch set
      logic [1:0]  prefetch_mod;
      logic [63:0] store_data;
      logic        fetch_fault;
   } ars_state_s;

   ars_state_s state_reg;
   ars_state_s state_next;

   ars_wr_s    int_wr;
   ars_wr_s    fp_wr;
   logic [63:0] load_image;
   logic [63:0] store_image;
   logic [63:0] fp_b_raw;

   // ======================================================================
   // Register files
   // ======================================================================
   // Link writes use the same port; the file drops index 31 on its own
   always_comb begin
      int_wr.en   = int_wr_en_in || link_wr_in;
      int_wr.idx  = int_wr_idx_in;
      int_wr.data = link_wr_in ? {state_reg.pc, 2'b00} : int_wr_data_in;
   end

   ars_regfile #(
      .WIDTH (XLEN),
      .DEPTH (NREGS)
   ) u_int_file (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .ra_idx_in   (int_ra_in),
      .rb_idx_in   (int_rb_in),
      .ra_data_out (int_ra_data_out),
      .rb_data_out (int_rb_data_out),
      .wr_en_in    (int_wr.en),
      .wr_idx_in   (int_wr.idx),
      .wr_data_in  (int_wr.data)
   );

   logic        load_take;

   // Codes 2 and 3 are not moves; only the two real kinds take the write port
   always_comb begin
      load_take = (ars_move_e'(load_kind_in) == ARS_MV_SINGLE) ||
                  (ars_move_e'(load_kind_in) == ARS_MV_DOUBLE);
   end

   // Loads take priority over operate results on the shared write port
   always_comb begin
      fp_wr.en  = fp_wr_en_in;
      fp_wr.idx = fp_wr_idx_in;
      if (load_take) begin
         fp_wr.data = load_image;
      end else if (lw_operate_in) begin
         fp_wr.data = fp_wr_data_in;
         fp_wr.data[`ARS_LW_GAP_HI:`ARS_LW_GAP_LO] = 3'h0;
      end else begin
         fp_wr.data = fp_wr_data_in;
      end
   end

   ars_regfile #(
      .WIDTH (XLEN),
      .DEPTH (NREGS)
   ) u_fp_file (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .ra_idx_in   (fp_ra_in),
      .rb_idx_in   (fp_rb_in),
      .ra_data_out (fp_ra_data_out),
      .rb_data_out (fp_b_raw),
      .wr_en_in    (fp_wr.en),
      .wr_idx_in   (fp_wr.idx),
      .wr_data_in  (fp_wr.data)
   );

   // Longword sources on port b see the gap bits as zero; port a is not masked
   always_comb begin
      fp_rb_data_out = fp_b_raw;
      if (lw_operate_in) begin
         fp_rb_data_out[`ARS_LW_GAP_HI:`ARS_LW_GAP_LO] = 3'h0;
      end
   end

   ars_fmove u_fmove (
      .load_kind_in  (load_kind_in),
      .mem_data_in   (load_mem_data_in),
      .reg_image_out (load_image),
      .store_kind_in (store_kind_in),
      .reg_data_in   (fp_ra_data_out),
      .mem_image_out (store_image)
   );

   // ======================================================================
   // Update strobes
   // ======================================================================
   // Each update is named once so the next-state block reads as a list
   // Counter
   logic        pc_take_target;
   logic        pc_take_step;
   logic [63:0] pc_byte;

   // Reservation
   logic        lock_to_zero;
   logic        lock_take;
   logic        lock_drop;

   // Prefetch
   logic        prefetch_take;
   logic        prefetch_to_b;

   // Store and fault
   logic        store_take;
   logic        fault_seen;

   // ======================================================================
   // Program counter control
   // ======================================================================
   // A redirect outranks the sequential step, so a jump decoded in the
   // same cycle lands on its target and never on the next word
   always_comb begin
      pc_take_target = redirect_in;
      pc_take_step   = decode_in && !redirect_in;
   end

   // Low two bits are not stored at all; they read back as zero
   always_comb begin
      pc_byte = {state_reg.pc, 2'b00};
   end

   // ======================================================================
   // Reservation control
   // ======================================================================
   // A reserve load naming the zero register may leave the reservation
   // in any state; here it simply leaves it untouched
   always_comb begin
      lock_to_zero = (int_wr_idx_in == `ARS_ZERO_IDX);
   end

   always_comb begin
      lock_take = load_reserve_op_in && !lock_to_zero;
   end

   // A store-conditional consumes the reservation whether it succeeds or not
   always_comb begin
      lock_drop = reserve_clear_in || store_reserve_op_in;
   end

   // ======================================================================
   // Prefetch control
   // ======================================================================
   // Two sets are filled in turn; neither is wired to any port, so
   // software can only ever reach them through the prefetch strobes
   always_comb begin
      prefetch_take = prefetch_in || prefetch_mod_in;
      prefetch_to_b = state_reg.prefetch_sel;
   end

   // ======================================================================
   // Store and fault control
   // ======================================================================
   // The store word is only refreshed by a real move; codes 2 and 3 hold it
   always_comb begin
      store_take = (ars_move_e'(store_kind_in) == ARS_MV_SINGLE) ||
                   (ars_move_e'(store_kind_in) == ARS_MV_DOUBLE);
   end

   // A fetch fault is reported even when the destination is a zero
   // register, since the discard only applies to the result
   always_comb begin
      fault_seen = fetch_fault_in;
   end

   // ======================================================================
   // Next state
   // ======================================================================
   // One copy of the state is edited field by field and then registered
   always_comb begin
      state_next = state_reg;

      // Program counter; it wraps at the top of the address space
      if (pc_take_target) begin
         state_next.pc = target_in[63:2];
      end else if (pc_take_step) begin
         state_next.pc = state_reg.pc + `ARS_PC_STEP;
      end

      // Reservation: a new reservation wins over a clear in the same cycle
      if (lock_take) begin
         state_next.lock_flag = 1'b1;
         state_next.lock_addr = reserve_addr_in;
      end else if (lock_drop) begin
         state_next.lock_flag = 1'b0;
      end

      // Prefetch sets alternate on every request
      if (prefetch_take) begin
         if (prefetch_to_b) begin
            state_next.prefetch_b      = prefetch_addr_in;
            state_next.prefetch_mod[1] = prefetch_mod_in;
         end else begin
            state_next.prefetch_a      = prefetch_addr_in;
            state_next.prefetch_mod[0] = prefetch_mod_in;
         end
         state_next.prefetch_sel = !state_reg.prefetch_sel;
      end

      // Store word is held a cycle so memory always sees a settled value
      if (store_take) begin
         state_next.store_data = store_image;
      end

      state_next.fetch_fault = fault_seen;

      // Synchronous reset; the reservation starts empty
      if (rst_in) begin
         state_next    = '0;
         state_next.pc = `ARS_PC_RESET;
      end
   end

   always_ff @(posedge clock_in) begin
      state_reg <= state_next;
   end

   // ======================================================================
   // Outputs
   // ======================================================================
   // Every output in this section is taken straight from a flip-flop
   always_comb begin
      program_counter_out = pc_byte;
   end

   // Store word
   always_comb begin
      store_mem_data_out = state_reg.store_data;
   end

   // Fault report
   always_comb begin
      fetch_fault_out = state_reg.fetch_fault;
   end

   // Reservation flag
   always_comb begin
      lock_flag_out = state_reg.lock_flag;
   end

   // Reserved address
   always_comb begin
      lock_addr_out = state_reg.lock_addr;
   end
endmodule

/* File: ars_core_assertions.sv */
`timescale 1ns/1ps
// ==========================================
// Checker on the register state ports
// ==========================================
module ars_core_assertions
   import ars_pkg::*;
(
   // Clock, reset and strobes
   input wire logic        clock_in, rst_in, decode_in, redirect_in,
   input wire logic        load_reserve_op_in, reserve_clear_in, lock_flag_out,
   // Indices and kinds
   input wire logic [4:0]  int_ra_in, int_rb_in, int_wr_idx_in, fp_ra_in,
   input wire logic [1:0]  store_kind_in,
   // Data
   input wire logic [63:0] target_in, program_counter_out, int_ra_data_out,
   input wire logic [63:0] int_rb_data_out, fp_ra_data_out, store_mem_data_out,
   input wire logic [63:0] reserve_addr_in, lock_addr_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   chk_int_zero_a: assert property (int_ra_in == 5'h1f |-> int_ra_data_out == 64'h0)
      else $error("int zero port a not zero");
   chk_int_zero_b: assert property (int_rb_in == 5'h1f |-> int_rb_data_out == 64'h0)
      else $error("int zero port b not zero");
   chk_fp_zero: assert property (fp_ra_in == 5'h1f |-> fp_ra_data_out == 64'h0)
      else $error("fp zero register not zero");
   chk_pc_align: assert property (program_counter_out[1:0] == 2'h0)
      else $error("counter low bits set");
   chk_pc_advance: assert property (decode_in && !redirect_in
      |=> program_counter_out == $past(program_counter_out) + 64'h4)
      else $error("counter did not advance by four");
   chk_pc_redirect: assert property (redirect_in
      |=> program_counter_out == {$past(target_in[63:2]), 2'h0})
      else $error("counter did not take target");
   chk_dbl_store: assert property (store_kind_in == ARS_MV_DOUBLE
      |=> store_mem_data_out == $past(fp_ra_data_out))
      else $error("double store reordered bits");
   chk_sgl_store: assert property (store_kind_in == ARS_MV_SINGLE
      |=> store_mem_data_out == {32'h0, $past(fp_ra_data_out[63:62]),
      $past(fp_ra_data_out[58:29])})
      else $error("single store image wrong");
   chk_lock_set: assert property (load_reserve_op_in && !reserve_clear_in
      && int_wr_idx_in != 5'h1f
      |=> lock_flag_out && lock_addr_out == $past(reserve_addr_in))
      else $error("reservation not taken");
   chk_lock_clear: assert property (reserve_clear_in && !load_reserve_op_in
      |=> !lock_flag_out)
      else $error("reservation not cleared");
   cov_decode: cover property (decode_in [*3]);
   cov_redirect: cover property (redirect_in);
   cov_lock: cover property (load_reserve_op_in ##1 reserve_clear_in);
endmodule

/* File: ars_fmove.sv */
`timescale 1ns/1ps
`include "ars_params.svh"
module ars_fmove
   import ars_pkg::*;
(
   // Load side
   input  wire logic [1:0]  load_kind_in,
   input  wire logic [63:0] mem_data_in,
   output logic [63:0]      reg_image_out,
   // Store side
   input  wire logic [1:0]  store_kind_in,
   input  wire logic [63:0] reg_data_in,
   output logic [63:0]      mem_image_out
);
   logic [7:0]  m_exp;
   logic [10:0] r_exp;

   always_comb begin
      m_exp = mem_data_in[30:23];
      if (m_exp == `ARS_EXP_ONES8) begin
         r_exp = `ARS_EXP_ONES11;
      end else if (m_exp == `ARS_EXP_ZERO8) begin
         r_exp = `ARS_EXP_ZERO11;
      end else begin
         r_exp = {m_exp[7], {3{~m_exp[7]}}, m_exp[6:0]};
      end
      unique case (ars_move_e'(load_kind_in))
         ARS_MV_SINGLE: reg_image_out = {mem_data_in[31], r_exp, mem_data_in[22:0],
                                         {`ARS_SP_LOW_W{1'b0}}};
         ARS_MV_DOUBLE: reg_image_out = mem_data_in;
         default:       reg_image_out = '0;
      endcase
      unique case (ars_move_e'(store_kind_in))
         // Bits 61:59 and 28:0 are dropped without checking
         ARS_MV_SINGLE: mem_image_out = {32'h0, reg_data_in[63:62],
                                         reg_data_in[58:29]};
         // No validity check; caller must have produced a quadword
         ARS_MV_DOUBLE: mem_image_out = reg_data_in;
         default:       mem_image_out = '0;
      endcase
   end
endmodule

/* File: ars_mem_model.sv */
`timescale 1ns/1ps
// ==========================================
// Memory side of the floating moves
// ==========================================
module ars_mem_model (
   // Select
   input  wire logic [1:0] sel_in,
   // Data
   output logic [63:0]     rd_data_out
);
   // Words chosen to hit every exponent class of the single load
   logic [63:0] mem_t [4] = '{64'h0123_4567_7f80_0001, 64'h89ab_cdef_0000_0005,
                              64'hfedc_ba98_c0a0_1234, 64'h1357_9bdf_3f12_3456};
   assign rd_data_out = mem_t[sel_in];
endmodule

/* File: ars_params.svh */
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH
`define ARS_XLEN        64
`define ARS_NREGS       32
`define ARS_ZERO_IDX    5'h1f
`define ARS_PC_STEP     62'h1
`define ARS_PC_RESET    62'h0
`define ARS_LW_SIGN     62
`define ARS_LW_GAP_HI   61
`define ARS_LW_GAP_LO   59
`define ARS_LW_HI_HI    58
`define ARS_LW_HI_LO    45
`define ARS_LW_LO_HI    44
`define ARS_LW_LO_LO    29
`define ARS_SP_LOW_W    29
`define ARS_EXP_ONES8   8'hff
`define ARS_EXP_ZERO8   8'h00
`define ARS_EXP_ONES11  11'h7ff
`define ARS_EXP_ZERO11  11'h000
`endif

/* File: ars_pkg.sv */
package ars_pkg;
   typedef logic [63:0] ars_word_t;
   typedef logic [4:0]  ars_idx_t;
   // Kind of a floating memory move
   typedef enum logic [1:0] {ARS_MV_SINGLE, ARS_MV_DOUBLE, ARS_MV_NONE} ars_move_e;
   // Register write request
   typedef struct packed {
      logic      en;
      ars_idx_t  idx;
      ars_word_t data;
   } ars_wr_s;
   // Program counter request
   typedef struct packed {
      logic        decode;
      logic        redirect;
      logic [63:0] target;
   } ars_pc_s;
   // Reservation request
   typedef struct packed {
      logic        set;
      logic        clear;
      logic [63:0] addr;
   } ars_lock_s;
endpackage

/* File: ars_regfile.sv */
`timescale 1ns/1ps
`include "ars_params.svh"
module ars_regfile
   import ars_pkg::*;
#(
   parameter int WIDTH = 64,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   // Read ports
   input  wire logic [4:0]       ra_idx_in,
   input  wire logic [4:0]       rb_idx_in,
   output logic [WIDTH-1:0]      ra_data_out,
   output logic [WIDTH-1:0]      rb_data_out,
   // Write port
   input  wire logic             wr_en_in,
   input  wire logic [4:0]       wr_idx_in,
   input  wire logic [WIDTH-1:0] wr_data_in
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   // Array kept out of reset to stay a plain RAM; only the zero index matters
   always_ff @(posedge clock_in) begin
      if (wr_en_in && wr_idx_in != `ARS_ZERO_IDX) begin
         mem_reg[wr_idx_in] <= wr_data_in;
      end
   end

   always_comb begin
      ra_data_out = (ra_idx_in == `ARS_ZERO_IDX) ? '0 : mem_reg[ra_idx_in];
      rb_data_out = (rb_idx_in == `ARS_ZERO_IDX) ? '0 : mem_reg[rb_idx_in];
   end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb
   import ars_pkg::*;
;
   logic clock_in, rst_in, decode_in, redirect_in, int_wr_en_in, link_wr_in, fp_wr_en_in,
      lw_operate_in, fetch_fault_in, fetch_fault_out, load_reserve_op_in, store_reserve_op_in,
      reserve_clear_in, lock_flag_out, prefetch_in, prefetch_mod_in;
   logic [4:0] int_ra_in, int_rb_in, int_wr_idx_in, fp_ra_in, fp_rb_in, fp_wr_idx_in;
   logic [1:0] load_kind_in, store_kind_in, mem_sel;
   logic [63:0] target_in, program_counter_out, int_ra_data_out, int_rb_data_out,
      int_wr_data_in, fp_ra_data_out, fp_rb_data_out, fp_wr_data_in, load_mem_data_in,
      store_mem_data_out, reserve_addr_in, lock_addr_out, prefetch_addr_in, w, e;
   int err_count, checks, cyc;
   ars_core i_dut (.*);
   ars_mem_model i_mem (.sel_in(mem_sel), .rd_data_out(load_mem_data_in));
   initial begin
      clock_in = 0;
      forever #50 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         tally_and_finish;
      end
   end
   task chk(input string n, input logic [63:0] g, input logic [63:0] x);
      checks++;
      if (g !== x) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task go;
      @(negedge clock_in);
      {decode_in, redirect_in, int_wr_en_in, link_wr_in, fp_wr_en_in, lw_operate_in} = '0;
      {fetch_fault_in, load_reserve_op_in, reserve_clear_in} = '0;
      load_kind_in = ARS_MV_NONE;
   endtask
   function automatic logic [63:0] sld(input logic [31:0] m);
      logic [10:0] x;
      x = (m[30:23] == 8'hff) ? 11'h7ff : (m[30:23] == 8'h00) ? 11'h000 :
          {m[30], {3{~m[30]}}, m[29:23]};
      return {m[31], x, m[22:0], 29'h0};
   endfunction
   task t_pc;
      chk("pc_reset", program_counter_out, 64'h0);
      decode_in = 1;
      repeat (2) @(negedge clock_in);
      go;
      chk("pc_step", program_counter_out, 64'hc);
      {redirect_in, link_wr_in, int_wr_en_in} = 3'h7;
      target_in = 64'h8000_0000_0000_1237;
      int_wr_idx_in = 5'h1f;
      int_wr_data_in = 64'hd;
      go;
      chk("pc_jump", program_counter_out, 64'h8000_0000_0000_1234);
      int_ra_in = 5'h1f;
      #1 chk("link_zero", int_ra_data_out, 64'h0);
      {link_wr_in, int_wr_idx_in} = {1'b1, 5'h4};
      go;
      int_ra_in = 5'h4;
      #1 chk("link_value", int_ra_data_out, 64'h8000_0000_0000_1234);
      $display("test pc done");
   endtask
   task t_files;
      for (int i = 0; i < 32; i++) begin
         {int_wr_en_in, fp_wr_en_in} = 2'h3;
         {int_wr_idx_in, fp_wr_idx_in} = {2{i[4:0]}};
         int_wr_data_in = 64'ha5a5_0000_0000_0000 | i;
         fp_wr_data_in = 64'h5a5a_0000_0000_0000 | i;
         go;
      end
      for (int i = 0; i < 32; i++) begin
         {int_ra_in, int_rb_in, fp_ra_in, fp_rb_in} = {4{i[4:0]}};
         #1 e = (i == 31) ? 64'h0 : 64'ha5a5_0000_0000_0000 | i;
         chk("int_a", int_ra_data_out, e);
         chk("int_b", int_rb_data_out, e);
         e = (i == 31) ? 64'h0 : 64'h5a5a_0000_0000_0000 | i;
         chk("fp_a", fp_ra_data_out, e);
         chk("fp_b", fp_rb_data_out, e);
      end
      $display("test files done");
   endtask
   task t_moves;
      for (int k = 0; k < 4; k++) begin
         mem_sel = k[1:0];
         #1 w = load_mem_data_in;
         load_kind_in = ARS_MV_SINGLE;
         fp_wr_en_in = 1;
         fp_wr_idx_in = 5'h1 + k[4:0];
         go;
         fp_ra_in = 5'h1 + k[4:0];
         store_kind_in = ARS_MV_SINGLE;
         #1 chk("single_load", fp_ra_data_out, sld(w[31:0]));
         @(negedge clock_in);
         chk("single_store", store_mem_data_out[31:0], w[31:0]);
      end
      {fp_wr_en_in, lw_operate_in} = 2'h3;
      fp_wr_idx_in = 5'h6;
      fp_wr_data_in = 64'h7fff_ffff_ffff_ffff;
      go;
      fp_ra_in = 5'h6;
      #1 chk("lw_operate", fp_ra_data_out, 64'h47ff_ffff_ffff_ffff);
      {lw_operate_in, fp_rb_in} = {1'b1, 5'h1};
      #1 chk("lw_source", fp_rb_data_out, 64'h47f0_0000_2000_0000);
      load_kind_in = ARS_MV_DOUBLE;
      fp_wr_en_in = 1;
      fp_wr_idx_in = 5'h8;
      go;
      fp_ra_in = 5'h8;
      store_kind_in = ARS_MV_DOUBLE;
      #1 chk("double_load", fp_ra_data_out, 64'h1357_9bdf_3f12_3456);
      @(negedge clock_in);
      chk("double_store", store_mem_data_out, 64'h1357_9bdf_3f12_3456);
      store_kind_in = ARS_MV_NONE;
      $display("test moves done");
   endtask
   task t_lock;
      load_reserve_op_in = 1;
      int_wr_idx_in = 5'h3;
      reserve_addr_in = 64'h0000_0000_0040_1238;
      go;
      chk("lock_flag", lock_flag_out, 64'h1);
      chk("lock_addr", lock_addr_out, 64'h0000_0000_0040_1238);
      reserve_clear_in = 1;
      go;
      chk("lock_clear", lock_flag_out, 64'h0);
      {fp_wr_en_in, fetch_fault_in} = 2'h3;
      fp_wr_idx_in = 5'h1f;
      @(negedge clock_in);
      chk("fetch_fault", fetch_fault_out, 64'h1);
      go;
      $display("test lock done");
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      {rst_in, decode_in, redirect_in, int_wr_en_in, link_wr_in, fp_wr_en_in} = 6'h20;
      {lw_operate_in, fetch_fault_in, load_reserve_op_in, store_reserve_op_in} = '0;
      {reserve_clear_in, prefetch_in, prefetch_mod_in} = '0;
      {int_ra_in, int_rb_in, int_wr_idx_in, fp_ra_in, fp_rb_in, fp_wr_idx_in} = '0;
      {load_kind_in, store_kind_in, mem_sel} = {ARS_MV_NONE, ARS_MV_NONE, 2'h0};
      {target_in, int_wr_data_in, fp_wr_data_in, reserve_addr_in, prefetch_addr_in} = '0;
      repeat (3) @(negedge clock_in);
      rst_in = 0;
      t_pc;
      t_files;
      t_moves;
      t_lock;
      tally_and_finish;
   end
endmodule
bind ars_core ars_core_assertions i_chk (.*);
